// *** lpodt_pkg.sv ***
package lpodt_pkg;
  // Burst length is fixed; only BL8 exists on this part
  localparam int unsigned LPODT_BURST_LEN = 8;
  // Default read latency in clock cycles
  localparam int unsigned LPODT_RL_DEFAULT = 12;
  // Width of the read latency input; the read window counters are one bit wider
  localparam int unsigned LPODT_RL_W = 6;
  // Two NOP cycles after CKE falls before the receivers switch off
  localparam int unsigned LPODT_CPDED_CYCLES = 2;
  // Turn-off is referenced this many cycles before read latency expires
  localparam int unsigned LPODT_RD_OFF_LEAD = 2;
  // Reset value of the registered termination enables
  localparam logic LPODT_TERM_RST = 1'b0;

  // Power state of the device
  typedef enum logic [1:0] {
    LPODT_ST_ACTIVE,
    LPODT_ST_PD_IDLE,
    LPODT_ST_PD_ACTIVE,
    LPODT_ST_DEEP
  } lpodt_pwr_t;
endpackage : lpodt_pkg

// *** lpodt_rd_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// Carries the read window request and answer between controller and timer
interface lpodt_rd_if;
  import lpodt_pkg::*;
  logic rd_start;
  logic [LPODT_RL_W-1:0] rl;
  logic rd_off;
  modport timer (input rd_start, input rl, output rd_off);
  modport ctrl (output rd_start, output rl, input rd_off);
endinterface : lpodt_rd_if
`default_nettype wire

// *** lpodt_rd_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
module lpodt_rd_timer
  import lpodt_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_n_in,
  lpodt_rd_if.timer rd
);
  logic [LPODT_RL_W:0] cnt_reg;
  logic [LPODT_RL_W:0] cnt_next;
  logic [LPODT_RL_W:0] off_cnt_reg;
  logic [LPODT_RL_W:0] off_cnt_next;
  logic running_reg;
  logic pend_reg;
  logic pend_next;
  logic off_reg;
  logic off_next;
  wire [LPODT_RL_W:0] off_edge;
  wire [LPODT_RL_W:0] on_edge;
  wire pend_start;
  wire hit_off;
  wire hit_on;

  // Window edges: RL-2 starts turn-off, RL+BL/2 starts turn-on
  assign off_edge = {1'b0, rd.rl} - (LPODT_RL_W+1)'(LPODT_RD_OFF_LEAD);
  assign on_edge = {1'b0, rd.rl} + (LPODT_RL_W+1)'(LPODT_BURST_LEN / 2);
  // Turn-off follows the oldest read still waiting, so a quick second read cannot delay it
  assign pend_start = rd.rd_start && !pend_reg && (!off_reg || hit_on);
  assign hit_off = pend_reg && (off_cnt_reg == off_edge);
  assign hit_on = running_reg && (cnt_reg == on_edge);
  assign off_cnt_next = pend_start ? '0 : off_cnt_reg + 1'b1;
  assign pend_next = pend_start || (pend_reg && !hit_off);
  // A newer read restarts the count, so turn-on follows the last burst
  assign cnt_next = rd.rd_start ? '0 : (hit_on ? cnt_reg : cnt_reg + 1'b1);
  // Off stays set across back-to-back reads; only the last read's end clears it
  assign off_next = hit_off ? 1'b1 : (hit_on ? 1'b0 : off_reg);
  assign rd.rd_off = off_reg;

  // Count cycles since the oldest waiting read and since the most recent read command
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_reg <= '0;
      off_cnt_reg <= '0;
      running_reg <= 1'b0;
      pend_reg <= 1'b0;
      off_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      off_cnt_reg <= off_cnt_next;
      running_reg <= rd.rd_start || (running_reg && !hit_on);
      pend_reg <= pend_next;
      off_reg <= off_next;
    end
  end
endmodule : lpodt_rd_timer
`default_nettype wire

// *** lpodt_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module lpodt_ctrl
  import lpodt_pkg::*;
#(
  parameter int unsigned CPDED_CYCLES = LPODT_CPDED_CYCLES
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic cke_in,
  input wire logic cs_n_in,
  input wire logic [2:0] ca_in,
  input wire logic odt_pin_in,
  input wire logic [1:0] term_setting_in,
  input wire logic pd_term_en_in,
  input wire logic write_level_in,
  input wire logic ca_train_in,
  input wire logic dq_cal_in,
  input wire logic zq_cal_in,
  input wire logic rd_cmd_in,
  input wire logic [LPODT_RL_W-1:0] read_latency_in,
  input wire logic bank_open_in,
  output logic dq_term_en_out,
  output logic dqs_term_en_out,
  output logic pd_idle_out,
  output logic pd_active_out,
  output logic deep_sleep_out,
  output logic rx_off_out,
  output logic refresh_block_out,
  output logic reinit_needed_out
);
  // Synchroniser width covers CKE, chip select, three CA bits and the termination pin
  localparam int unsigned SYNC_W = 6;
  // Two bits hold the NOP count; a larger entry delay needs a wider counter
  localparam int unsigned NOP_W = 2;

  // The read timer shares one interface for its start pulse, latency and answer
  lpodt_rd_if rd_bus ();

  // Pins pass two flip-flops; the first stage feeds only the second
  logic [SYNC_W-1:0] sync1_reg;
  logic [SYNC_W-1:0] sync2_reg;
  logic cke_prev_reg;
  lpodt_pwr_t state_reg;
  lpodt_pwr_t state_next;
  logic [NOP_W-1:0] nop_cnt_reg;
  logic [NOP_W-1:0] nop_cnt_next;
  logic dq_term_reg;
  logic dqs_term_reg;
  logic reinit_reg;

  wire cke_s;
  wire cs_n_s;
  wire [2:0] ca_s;
  wire odt_s;
  wire cke_fall;
  wire cke_rise;
  wire deep_cmd;
  wire pd_cmd;
  wire in_pd;
  wire in_sleep;
  wire is_active;
  wire is_deep;
  wire term_base;
  wire rd_block;
  wire mode_block;
  wire sleep_block;
  wire term_block;
  wire reinit_set;
  wire reinit_clr;
  wire reinit_next;
  wire dq_term_next;
  wire dqs_term_next;

  // Unpack in the order the pins were packed into the first stage
  assign {cke_s, cs_n_s, ca_s, odt_s} = sync2_reg;

  // Entry and exit decode on the sampled CKE edge
  // A fall needs CKE seen high first, which keeps a low pin at reset from entering sleep
  assign cke_fall = cke_prev_reg && !cke_s;
  assign cke_rise = !cke_prev_reg && cke_s;
  assign deep_cmd = cke_fall && !cs_n_s && ca_s[0] && ca_s[1] && !ca_s[2];
  assign pd_cmd = cke_fall && cs_n_s;
  // State decode shared by the termination mask, the read gate and the status pins
  assign is_active = (state_reg == LPODT_ST_ACTIVE);
  assign is_deep = (state_reg == LPODT_ST_DEEP);
  assign in_pd = (state_reg == LPODT_ST_PD_IDLE) || (state_reg == LPODT_ST_PD_ACTIVE);
  assign in_sleep = in_pd || is_deep;

  // Next power state; exit needs CKE high, chip select high is the far side's duty
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      LPODT_ST_ACTIVE: begin
        // Entry is taken only here; a second CKE fall while asleep is ignored
        if (deep_cmd) begin
          state_next = LPODT_ST_DEEP;
        end else if (pd_cmd) begin
          state_next = bank_open_in ? LPODT_ST_PD_ACTIVE : LPODT_ST_PD_IDLE;
        end
      end
      LPODT_ST_PD_IDLE, LPODT_ST_PD_ACTIVE, LPODT_ST_DEEP: begin
        // Exit checks CKE alone; holding chip select high is left to the controller
        if (cke_rise) begin
          state_next = LPODT_ST_ACTIVE;
        end
      end
    endcase
  end

  // Receivers drop only after the two NOP cycles following CKE low
  // The count saturates, so receivers stay off until the state leaves sleep
  assign nop_cnt_next = !in_sleep ? '0 :
                        (nop_cnt_reg == NOP_W'(CPDED_CYCLES)) ? nop_cnt_reg : nop_cnt_reg + 1'b1;

  // Read window timer; every read or MRR restarts its turn-on count
  // Reads are refused outside the active state, so a stray pulse cannot mask termination
  assign rd_bus.rd_start = rd_cmd_in && is_active;
  assign rd_bus.rl = read_latency_in;

  // Timer answer is registered, so the mask sees it one edge after the window edge
  lpodt_rd_timer u_rd_timer (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .rd(rd_bus.timer)
  );

  // Termination: pin and setting enable it, any disabling condition wins
  // The pin only counts once it has passed the synchroniser
  assign term_base = (term_setting_in != 2'h0) && odt_s;
  // Each disabling source is a named term so a new mode joins the mask in one place
  assign rd_block = rd_bus.rd_off;
  assign mode_block = dq_cal_in || zq_cal_in || ca_train_in;
  // Deepest sleep always drops termination; plain power-down keeps it only on request
  assign sleep_block = is_deep || (in_pd && !pd_term_en_in);
  assign term_block = rd_block || mode_block || sleep_block;
  assign dqs_term_next = term_base && !term_block;
  // DQ follows DQS but write leveling holds it off regardless of the pin
  assign dq_term_next = dqs_term_next && !write_level_in;

  // Pin synchronisers and CKE history
  // CKE history resets low, so the first high sample after reset reads as a harmless exit
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      cke_prev_reg <= 1'b0;
    end else begin
      sync1_reg <= {cke_in, cs_n_in, ca_in, odt_pin_in};
      sync2_reg <= sync1_reg;
      cke_prev_reg <= cke_s;
    end
  end

  // Contents are lost in the deepest state; the flag stands until the first read after exit
  // Set and clear never meet: reads are refused while the state is still deep
  assign reinit_set = is_deep;
  assign reinit_clr = rd_bus.rd_start;
  assign reinit_next = reinit_set || (reinit_reg && !reinit_clr);

  // Power state, NOP counter and re-init flag
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= LPODT_ST_ACTIVE;
      nop_cnt_reg <= '0;
      reinit_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      nop_cnt_reg <= nop_cnt_next;
      reinit_reg <= reinit_next;
    end
  end

  // Registered termination enables
  // Registering both keeps mask glitches off the termination switches
  // Both reset off so nothing terminates before the first pin sample
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dq_term_reg <= LPODT_TERM_RST;
      dqs_term_reg <= LPODT_TERM_RST;
    end else begin
      dq_term_reg <= dq_term_next;
      dqs_term_reg <= dqs_term_next;
    end
  end

  // Status outputs
  // State pins decode the state register directly, so they move on the state edge
  assign dq_term_en_out = dq_term_reg;
  assign dqs_term_en_out = dqs_term_reg;
  assign pd_idle_out = (state_reg == LPODT_ST_PD_IDLE);
  assign pd_active_out = (state_reg == LPODT_ST_PD_ACTIVE);
  assign deep_sleep_out = is_deep;
  assign rx_off_out = in_sleep && (nop_cnt_reg == NOP_W'(CPDED_CYCLES));
  assign refresh_block_out = in_sleep;
  assign reinit_needed_out = reinit_reg;
endmodule : lpodt_ctrl
`default_nettype wire

// *** lpodt_ctrl_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module lpodt_ctrl_monitor
  import lpodt_pkg::*;
#(
  parameter int unsigned CPDED_CYCLES = LPODT_CPDED_CYCLES
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic cke_in,
  input wire logic cs_n_in,
  input wire logic [2:0] ca_in,
  input wire logic [1:0] term_setting_in,
  input wire logic pd_term_en_in,
  input wire logic write_level_in,
  input wire logic ca_train_in,
  input wire logic dq_cal_in,
  input wire logic zq_cal_in,
  input wire logic rd_cmd_in,
  input wire logic [LPODT_RL_W-1:0] read_latency_in,
  input wire logic dq_term_en_out,
  input wire logic dqs_term_en_out,
  input wire logic pd_idle_out,
  input wire logic pd_active_out,
  input wire logic deep_sleep_out,
  input wire logic rx_off_out
);
  logic sleep;
  logic [6:0] rd_cnt_reg;
  assign sleep = pd_idle_out | pd_active_out | deep_sleep_out;
  // Cycles since the last accepted read; saturates so stale reads stop counting
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) rd_cnt_reg <= 7'h7f;
    else if (rd_cmd_in && !sleep) rd_cnt_reg <= 7'h01;
    else if (rd_cnt_reg != 7'h7f) rd_cnt_reg <= rd_cnt_reg + 7'h01;
  end
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_n_in);
  a_wl_dq_off: assert property (write_level_in |=> !dq_term_en_out)
    else $error("dq termination on in write leveling");
  a_modes_term_off: assert property ((dq_cal_in | zq_cal_in | ca_train_in) |=> !dqs_term_en_out)
    else $error("termination on in calibration or training");
  a_zero_setting_off: assert property (term_setting_in == 2'h0 |=> !dqs_term_en_out)
    else $error("termination on with zero setting");
  a_read_window_off: assert property (rd_cnt_reg > 7'(read_latency_in) &&
    rd_cnt_reg <= 7'(read_latency_in) + 7'h06 |-> !dqs_term_en_out) else $error("termination on in read window");
  a_pd_term_off: assert property ((pd_idle_out | pd_active_out) && !pd_term_en_in |=> !dqs_term_en_out)
    else $error("termination on in power-down");
  a_pd_entry_seen: assert property ($fell(cke_in) && cs_n_in && !sleep |-> ##[2:4] (pd_idle_out | pd_active_out))
    else $error("power-down not entered");
  a_deep_entry_seen: assert property ($fell(cke_in) && !cs_n_in && ca_in == 3'h3 && !sleep |-> ##[2:4] deep_sleep_out)
    else $error("deepest sleep not entered");
  a_rx_off_late: assert property ($rose(sleep) |-> !rx_off_out ##CPDED_CYCLES rx_off_out)
    else $error("receivers off at wrong time");
  c_pd_active: cover property ($rose(pd_active_out));
  c_deep: cover property ($rose(deep_sleep_out));
  c_rd_off: cover property ($fell(dqs_term_en_out) && !sleep);
endmodule : lpodt_ctrl_monitor
bind lpodt_ctrl lpodt_ctrl_monitor #(.CPDED_CYCLES(CPDED_CYCLES)) u_mon (
  .clock_in(clock_in),
  .rst_n_in(rst_n_in),
  .cke_in(cke_in),
  .cs_n_in(cs_n_in),
  .ca_in(ca_in),
  .term_setting_in(term_setting_in),
  .pd_term_en_in(pd_term_en_in),
  .write_level_in(write_level_in),
  .ca_train_in(ca_train_in),
  .dq_cal_in(dq_cal_in),
  .zq_cal_in(zq_cal_in),
  .rd_cmd_in(rd_cmd_in),
  .read_latency_in(read_latency_in),
  .dq_term_en_out(dq_term_en_out),
  .dqs_term_en_out(dqs_term_en_out),
  .pd_idle_out(pd_idle_out),
  .pd_active_out(pd_active_out),
  .deep_sleep_out(deep_sleep_out),
  .rx_off_out(rx_off_out)
);
`default_nettype wire

// *** lpodt_mc_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Controller side: req 1 power-down, 2 deepest sleep, 3 exit, 0 plain NOP
module lpodt_mc_model (
  input wire logic clock_in,
  input wire logic [1:0] req_in,
  output logic cke_out,
  output logic cs_n_out,
  output logic [2:0] ca_out
);
  logic [1:0] r;
  initial begin
    cke_out = 1'b1;
    cs_n_out = 1'b1;
    ca_out = 3'h7;
  end
  // Request taken at the edge, pins moved just after it
  always @(posedge clock_in) begin
    r = req_in;
    #1;
    ca_out = ~ca_out; // Ignored bus keeps moving so stale values never pass
    cs_n_out = 1'b1; // NOP after every command
    if (r == 2'h1) cke_out = 1'b0;
    if (r == 2'h2) begin
      cke_out = 1'b0;
      cs_n_out = 1'b0;
      ca_out = 3'h3;
    end
    if (r == 2'h3) cke_out = 1'b1; // CS stays high on exit
  end
endmodule : lpodt_mc_model
`default_nettype wire

// *** lpddr3_power_down_odt_control_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module lpddr3_power_down_odt_control_tb;
  import lpodt_pkg::*;
  logic clk, rst_n, cke, cs_n, pin, pdte, wl, catr, dqc, zqc, rd, bank;
  logic dq, dqs, pdi, pda, deep, rxo, rfb, rein;
  logic [2:0] ca;
  logic [1:0] set, req;
  logic [LPODT_RL_W-1:0] rl;
  int mismatches, samples_checked, seed, k;
  lpodt_mc_model mc (.clock_in(clk), .req_in(req), .cke_out(cke), .cs_n_out(cs_n), .ca_out(ca));
  lpodt_ctrl uut (.clock_in(clk), .rst_n_in(rst_n), .cke_in(cke), .cs_n_in(cs_n), .ca_in(ca), .odt_pin_in(pin),
    .term_setting_in(set), .pd_term_en_in(pdte), .write_level_in(wl), .ca_train_in(catr), .dq_cal_in(dqc),
    .zq_cal_in(zqc), .rd_cmd_in(rd), .read_latency_in(rl), .bank_open_in(bank), .dq_term_en_out(dq),
    .dqs_term_en_out(dqs), .pd_idle_out(pdi), .pd_active_out(pda), .deep_sleep_out(deep), .rx_off_out(rxo),
    .refresh_block_out(rfb), .reinit_needed_out(rein));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Expected {dqs, dq}; any disabling condition wins over the pin
  function automatic logic [7:0] exp_term(input logic off);
    logic s;
    s = set != 2'h0 && pin && !(catr || dqc || zqc || off);
    return {6'h00, s, s & !wl};
  endfunction : exp_term
  task automatic final_report;
    $display("Checks %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report
  initial begin
    tick(3000);
    mismatches++;
    final_report();
  end
  initial begin
    seed = 32'hbbfc;
    {rst_n, pin, pdte, wl, catr, dqc, zqc, rd, bank, req, set} = '0;
    rl = 6'h08;
    tick(4);
    rst_n = 1'b1;
    // Every mode and pin combination, random setting field
    for (k = 0; k < 32; k++) begin
      {pin, wl, catr, dqc, zqc} = k[4:0];
      set = 2'($random(seed));
      tick(4);
      chk("term", exp_term(1'b0), {6'h00, dqs, dq});
    end
    $display("Test modes done");
    // Back-to-back reads: second extends the window, turn-off stays with the first
    {pin, wl, catr, dqc, zqc, set} = 7'h43;
    rl = 6'(4 + {$random(seed)} % 8);
    tick(4);
    for (k = 0; k < rl + 14; k++) begin
      rd = (k == 0 || k == 3);
      tick(1);
      chk("rd_term", exp_term(k >= rl && k < rl + 9), {6'h00, dqs, dq});
    end
    $display("Test read done");
    // Idle and active power-down, termination kept or dropped
    for (k = 0; k < 4; k++) begin
      {bank, pdte} = k[1:0];
      req = 2'h1; // Read, write, MRW and hold waits long over
      tick(1);
      req = 2'h0;
      tick(8); // CKE low held
      chk("pd", {3'h0, 1'b0, 1'b1, 1'b1, bank, !bank}, {3'h0, deep, rxo, rfb, pda, pdi});
      chk("pd_term", exp_term(!pdte), {6'h00, dqs, dq});
      req = 2'h3;
      tick(1);
      req = 2'h0;
      tick(8); // Exit latency
      chk("pd_exit", 8'h00, {3'h0, deep, rxo, rfb, pda, pdi});
    end
    $display("Test power-down done");
    bank = 1'b0;
    req = 2'h2;
    tick(1);
    req = 2'h0;
    tick(8);
    chk("deep", 8'h1c, {3'h0, deep, rxo, rfb, pda, pdi});
    chk("deep_term", exp_term(1'b1), {6'h00, dqs, dq});
    req = 2'h3;
    tick(1);
    req = 2'h0;
    tick(8);
    chk("reinit", 8'h01, {7'h00, rein});
    rd = 1'b1;
    tick(1);
    rd = 1'b0;
    tick(2);
    chk("reinit_clr", 8'h00, {7'h00, rein});
    $display("Test deep done");
    final_report();
  end
endmodule : lpddr3_power_down_odt_control_tb
`default_nettype wire
